// ===== hdl/ubi_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none
module ubi_baud_gen
  import ubi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Divisor
  input wire logic [15:0] divisor,
  input wire logic reload,
  // Output
  output logic tick16
);
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [15:0] cnt_reg, cnt_next;
  logic ref_tick;
  logic tick_next;

  // 20 MHz to 1.8432 MHz enable, exact on average
  always_comb begin
    ref_tick = (acc_reg >= ACC_MOD - ACC_STEP);
    if (ref_tick) begin
      acc_next = acc_reg + ACC_STEP - ACC_MOD;
    end else begin
      acc_next = acc_reg + ACC_STEP;
    end
  end

  // Divisor zero gives no output rather than a runaway count
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (reload) begin
      cnt_next = divisor;
    end else if (ref_tick && divisor != 16'h0000) begin
      if (cnt_reg <= 16'h0001) begin
        cnt_next = divisor;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
      cnt_reg <= 16'h0000;
      tick16 <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      tick16 <= tick_next;
    end
  end

  reload_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    reload |=> cnt_reg == $past(divisor)) else $error("counter not reloaded");
  tick_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
    tick16 |-> $past(ref_tick) && $past(cnt_reg) <= 16'h0001 && !$past(reload))
    else $error("tick without count expiry");
  cov_tick_c: cover property (@(posedge ref_clk) disable iff (rst) tick16);
endmodule : ubi_baud_gen
`default_nettype wire

// ===== hdl/ubi_int_prio.sv
`timescale 1ns/100ps
`default_nettype none
module ubi_int_prio
  import ubi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Enabled pending sources and identification read
  input wire ubi_src_t pend_en,
  input wire logic rd_iir,
  // Reported identification
  output logic [2:0] id
);
  ubi_frz_t frz_reg, frz_next;
  logic [2:0] held_reg, held_next;
  logic [2:0] live_id;
  logic release_held;

  always_comb begin
    live_id = ubi_top_id(pend_en);
    release_held = (ubi_id_src(held_reg) & pend_en) == '0;
    id = (frz_reg == FRZ_HOLD) ? held_reg : live_id;
  end

  // Transmit-empty is cleared by the read itself, so it is never held
  always_comb begin
    frz_next = frz_reg;
    held_next = held_reg;
    case (frz_reg)
      FRZ_IDLE: begin
        if (rd_iir && live_id != IID_NONE && live_id != IID_THRE) begin
          frz_next = FRZ_HOLD;
          held_next = live_id;
        end
      end
      FRZ_HOLD: begin
        if (release_held) begin
          frz_next = FRZ_IDLE;
          held_next = IID_NONE;
        end
      end
      default: begin
        frz_next = FRZ_IDLE;
        held_next = IID_NONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frz_reg <= FRZ_IDLE;
      held_reg <= IID_NONE;
    end else begin
      frz_reg <= frz_next;
      held_reg <= held_next;
    end
  end

  held_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
    frz_reg == FRZ_HOLD && !release_held |=> id == $past(id))
    else $error("held identification changed before service");
  cov_freeze_c: cover property (@(posedge ref_clk) disable iff (rst)
    frz_reg == FRZ_IDLE ##1 frz_reg == FRZ_HOLD ##[1:20] frz_reg == FRZ_IDLE);
endmodule : ubi_int_prio
`default_nettype wire

// ===== hdl/ubi_top.sv
// Contract
// - Read/write upper divisor byte, bits 7..0 are divisor bits 15..8.
// - Divide 1.8432 MHz by the 16-bit divisor to make the 16x clock.
// - Each source reaches the interrupt only when enabled; all off means quiet.
// - Enable bits: 3 modem, 2 line status, 1 transmit empty, 0 receive data.
// - Priority: line status, receive data, transmit empty, modem status.
// - Reading identification holds the top pending interrupt until serviced.
// - Identification bit 0 reads 1 when nothing pending, 0 otherwise.
// - Codes: 001 none, 110 line, 100 receive, 010 transmit, 000 modem.
// - Clears: line status read, buffer read, id read or transmit write, modem read.
// - Writing either divisor byte reloads the baud counter at once.
// - Divisor bytes reachable only while access-select is 1.
// - Interrupt reaches the channel only while output-two is set.
`timescale 1ns/100ps
`default_nettype none
module ubi_top
  import ubi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register access port
  input wire ubi_bus_t bus,
  output logic [7:0] rdata,
  // Bits held by the line and modem control registers
  input wire logic dlab,
  input wire logic out2,
  // Low divisor byte from its own register
  input wire logic [7:0] div_low,
  input wire logic div_low_wr,
  // Interrupt source events, one-cycle pulses
  input wire ubi_src_t src_ev,
  // Outputs
  output logic baud16_tick,
  output logic [7:0] div_high,
  output logic chip_int,
  output logic int_out
);
  logic [3:0] ier_reg, ier_next;
  logic [7:0] dlm_reg, dlm_next;
  logic [7:0] rdata_reg, rdata_next;
  ubi_src_t pend_reg, pend_next;
  ubi_src_t pend_en;
  ubi_src_t clr;
  logic [2:0] iir_id;
  logic rd_ier, wr_ier, rd_dlm, wr_dlm, rd_iir;
  logic rd_lsr, rd_msr, rd_rbr, wr_thr;
  logic rd_any;

  // Address decode
  always_comb begin
    rd_any = bus.cs && bus.rd;
    rd_ier = rd_any && bus.addr == ADDR_IER_DLM && !dlab;
    rd_dlm = rd_any && bus.addr == ADDR_IER_DLM && dlab;
    wr_ier = bus.cs && bus.wr && bus.addr == ADDR_IER_DLM && !dlab;
    wr_dlm = bus.cs && bus.wr && bus.addr == ADDR_IER_DLM && dlab;
    rd_iir = rd_any && bus.addr == ADDR_IIR;
    rd_lsr = rd_any && bus.addr == ADDR_LSR;
    rd_msr = rd_any && bus.addr == ADDR_MSR;
    rd_rbr = rd_any && bus.addr == ADDR_DATA && !dlab;
    wr_thr = bus.cs && bus.wr && bus.addr == ADDR_DATA && !dlab;
  end

  // Register state
  always_comb begin
    ier_next = ier_reg;
    dlm_next = dlm_reg;
    if (wr_ier) begin
      ier_next = bus.wdata[3:0];
    end
    if (wr_dlm) begin
      dlm_next = bus.wdata;
    end
  end

  // Pending flags; a new event in the clearing cycle survives
  always_comb begin
    pend_en = pend_reg & ubi_src_t'(ier_reg);
    clr.rls = rd_lsr;
    clr.rda = rd_rbr;
    clr.msr = rd_msr;
    clr.thre = wr_thr || (rd_iir && iir_id == IID_THRE);
    pend_next = (pend_reg & ~clr) | src_ev;
  end

  ubi_int_prio u_prio (
    .ref_clk(ref_clk),
    .rst(rst),
    .pend_en(pend_en),
    .rd_iir(rd_iir),
    .id(iir_id)
  );

  // The counter is reloaded with the byte being written, not the one it replaces
  ubi_baud_gen u_baud (
    .ref_clk(ref_clk),
    .rst(rst),
    .divisor({dlm_next, div_low}),
    .reload(wr_dlm || div_low_wr),
    .tick16(baud16_tick)
  );

  // Read data is registered; foreign addresses answer zero, for an outside mux
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_ier) begin
      rdata_next = {4'h0, ier_reg};
    end else if (rd_dlm) begin
      rdata_next = dlm_reg;
    end else if (rd_iir) begin
      rdata_next = {5'h00, iir_id};
    end else if (rd_any) begin
      rdata_next = RDATA_RESET;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ier_reg <= IER_RESET;
      dlm_reg <= DLM_RESET;
      rdata_reg <= RDATA_RESET;
      pend_reg <= '0;
    end else begin
      ier_reg <= ier_next;
      dlm_reg <= dlm_next;
      rdata_reg <= rdata_next;
      pend_reg <= pend_next;
    end
  end

  // Output-two gates the channel line; the raw level stays visible
  always_comb begin
    rdata = rdata_reg;
    div_high = dlm_reg;
    chip_int = pend_en != '0;
    int_out = chip_int && out2;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  dlm_write_a: assert property (wr_dlm |=> div_high == $past(bus.wdata))
    else $error("upper divisor byte not written");
  dlm_guard_a: assert property (bus.cs && bus.wr && bus.addr == ADDR_IER_DLM && !dlab
    |=> $stable(div_high)) else $error("divisor written with access-select clear");
  ier_rsvd_a: assert property (rd_ier |=> rdata[7:4] == 4'h0 && rdata[3:0] == ier_reg)
    else $error("enable readback wrong");
  all_off_a: assert property (ier_reg == 4'h0 |-> !chip_int && !int_out)
    else $error("interrupt with all enables clear");
  ev_int_a: assert property ((src_ev & ubi_src_t'(ier_reg)) != '0 && !wr_ier |=> chip_int)
    else $error("enabled event did not raise interrupt");
  out2_gate_a: assert property (!out2 |-> !int_out)
    else $error("interrupt passed with output-two clear");
  iir_none_a: assert property (rd_iir && iir_id == IID_NONE |=> rdata == 8'h01)
    else $error("idle identification not 01");
  rls_top_a: assert property (rd_iir && pend_en.rls && u_prio.frz_reg == FRZ_IDLE
    |=> rdata[2:0] == IID_RLS) else $error("line status not top");
  dlm_reload_a: assert property (wr_dlm |=> u_baud.cnt_reg == {div_high, $past(div_low)})
    else $error("counter not loaded with new divisor");
  ier_write_a: assert property (wr_ier |=> ier_reg == $past(bus.wdata[3:0]))
    else $error("enable bits not written");
  iir_rsvd_a: assert property (rd_iir |=> rdata[7:3] == 5'h00)
    else $error("identification upper bits not zero");
  iir_pend_a: assert property (rd_iir && chip_int |=> rdata[0] == 1'b0)
    else $error("pending flag not shown in identification");
  out2_pass_a: assert property (out2 && chip_int |-> int_out)
    else $error("interrupt blocked with output-two set");
  thre_id_clr_a: assert property (rd_iir && iir_id == IID_THRE && !src_ev.thre |=> !pend_reg.thre)
    else $error("transmit empty not cleared by identification read");
  rda_clr_a: assert property (rd_rbr && !src_ev.rda |=> !pend_reg.rda)
    else $error("receive data not cleared by buffer read");
  msr_clr_a: assert property (rd_msr && !src_ev.msr |=> !pend_reg.msr)
    else $error("modem status not cleared by its read");
  thre_clr_a: assert property (wr_thr && !src_ev.thre |=> !pend_reg.thre)
    else $error("transmit empty not cleared by write");
  set_wins_a: assert property (rd_lsr && src_ev.rls |=> pend_reg.rls)
    else $error("event lost in clearing cycle");

  cov_thre_id_c: cover property (rd_iir && iir_id == IID_THRE);
  cov_int_c: cover property ($rose(int_out));
  cov_rls_c: cover property (rd_iir && iir_id == IID_RLS ##[1:20] rd_lsr);
endmodule : ubi_top
`default_nettype wire

// ===== inc/ubi_pkg.sv
`default_nettype none
package ubi_pkg;
  // Register select codes on the 3-bit address port
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER_DLM = 3'h1;
  localparam logic [2:0] ADDR_IIR = 3'h2;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;

  // Enable register field positions and reset values
  localparam int IER_RDA_BIT = 0;
  localparam int IER_THRE_BIT = 1;
  localparam int IER_RLS_BIT = 2;
  localparam int IER_MSR_BIT = 3;
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [7:0] DLM_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Identification codes, bits 2..0
  localparam logic [2:0] IID_NONE = 3'h1;
  localparam logic [2:0] IID_RLS = 3'h6;
  localparam logic [2:0] IID_RDA = 3'h4;
  localparam logic [2:0] IID_THRE = 3'h2;
  localparam logic [2:0] IID_MSR = 3'h0;

  // Clock rates; the baud reference is made by a fractional accumulator
  localparam int REF_CLK_HZ = 20_000_000;
  localparam int BAUD_REF_HZ = 1_843_200;
  localparam int ACC_GCD = 6400;
  localparam int ACC_W = 12;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BAUD_REF_HZ / ACC_GCD);
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(REF_CLK_HZ / ACC_GCD);

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ubi_bus_t;

  // Bit order matches the enable register, bit 3 down to bit 0
  typedef struct packed {
    logic msr;
    logic rls;
    logic thre;
    logic rda;
  } ubi_src_t;

  typedef enum logic [0:0] {
    FRZ_IDLE = 1'h0,
    FRZ_HOLD = 1'h1
  } ubi_frz_t;

  function automatic logic [2:0] ubi_top_id(input ubi_src_t p);
    if (p.rls) return IID_RLS;
    else if (p.rda) return IID_RDA;
    else if (p.thre) return IID_THRE;
    else if (p.msr) return IID_MSR;
    else return IID_NONE;
  endfunction : ubi_top_id

  function automatic ubi_src_t ubi_id_src(input logic [2:0] id);
    ubi_src_t s;
    s = '0;
    case (id)
      IID_RLS: s.rls = 1'b1;
      IID_RDA: s.rda = 1'b1;
      IID_THRE: s.thre = 1'b1;
      IID_MSR: s.msr = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction : ubi_id_src
endpackage : ubi_pkg
`default_nettype wire

// ===== tb/uart_baud_and_interrupt_id_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module uart_baud_and_interrupt_id_tb;
  import ubi_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, dlab = 1'b0, out2 = 1'b0, div_low_wr = 1'b0;
  logic [7:0] div_low = 8'h00, rdata, div_high, d, v;
  logic [3:0] src_ev = 4'h0, pm = 4'h0, ier = 4'h0;
  ubi_bus_t bus;
  logic baud16_tick, chip_int, int_out;
  int n_fail = 0, checks_done = 0, fz = -1, ticks;

  ubi_top u_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .dlab(dlab),
    .out2(out2), .div_low(div_low), .div_low_wr(div_low_wr), .src_ev(src_ev),
    .baud16_tick(baud16_tick), .div_high(div_high), .chip_int(chip_int), .int_out(int_out));
  ubi_host u_host (.ref_clk(ref_clk), .bus(bus), .rdata(rdata));

  always #25 ref_clk = ~ref_clk;

  function automatic logic [7:0] code(input int i);
    return i == 2 ? 8'h06 : i == 0 ? 8'h04 : i == 1 ? 8'h02 : 8'h00;
  endfunction : code

  // A frozen code stays until its own source is serviced or disabled
  function automatic logic [7:0] exp_id();
    if (fz >= 0 && pm[fz] && ier[fz]) return code(fz);
    if (pm[2] & ier[2]) return 8'h06;
    if (pm[0] & ier[0]) return 8'h04;
    if (pm[1] & ier[1]) return 8'h02;
    if (pm[3] & ier[3]) return 8'h00;
    return 8'h01;
  endfunction : exp_id

  task automatic chk_int();
    `CHK(chip_int, |(ier & pm))
    `CHK(int_out, |(ier & pm) & out2)
  endtask : chk_int

  task automatic chk_iir();
    logic [7:0] e;
    e = exp_id();
    u_host.rd(ADDR_IIR, d);
    `CHK(d, e)
    if (e == 8'h02) pm[1] = 1'b0;
    fz = e == 8'h06 ? 2 : e == 8'h04 ? 0 : e == 8'h00 ? 3 : -1;
    #1 chk_int();
  endtask : chk_iir

  task automatic pulse(input logic [3:0] s);
    @(posedge ref_clk) src_ev <= s;
    @(posedge ref_clk) src_ev <= 4'h0;
    pm = pm | s;
    #1 chk_int();
  endtask : pulse

  task automatic clr(input int i);
    if (i == 1) u_host.wr(ADDR_DATA, 8'h5a);
    else u_host.rd(i == 0 ? ADDR_DATA : i == 2 ? ADDR_LSR : ADDR_MSR, d);
    pm[i] = 1'b0;
    if (fz == i) fz = -1;
    #1 chk_int();
  endtask : clr

  task automatic setd(input logic x);
    @(posedge ref_clk) dlab <= x;
  endtask : setd

  task automatic wier(input logic [7:0] x);
    u_host.wr(ADDR_IER_DLM, x);
    ier = x[3:0];
    #1 chk_int();
    u_host.rd(ADDR_IER_DLM, d);
    `CHK(d, {4'h0, x[3:0]})
  endtask : wier

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial begin
    #5000000;
    n_fail++;
    end_of_test();
  end

  initial begin
    void'($urandom(79));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    #1 `CHK(div_high, 8'h00)
    chk_iir();
    setd(1'b1);
    repeat (4) begin
      v = 8'($urandom);
      u_host.wr(ADDR_IER_DLM, v);
      u_host.rd(ADDR_IER_DLM, d);
      `CHK(d, v)
      `CHK(div_high, v)
    end
    setd(1'b0);
    u_host.rd(ADDR_IER_DLM, d);
    `CHK(d, 8'h00)
    wier(8'hf0 | 8'($urandom));
    wier(8'h0f);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) out2 <= i[0];
      pulse(4'(1 << i));
      chk_iir();
      clr(i);
      chk_iir();
    end
    pulse(4'hf);
    chk_iir();
    clr(2);
    chk_iir();
    clr(0);
    clr(1);
    chk_iir();
    clr(3);
    chk_iir();
    // Freeze: a higher source arriving after the read must not replace the held code
    pulse(4'h8);
    chk_iir();
    pulse(4'h4);
    chk_iir();
    clr(3);
    chk_iir();
    clr(2);
    wier(8'h00);
    pulse(4'hf);
    chk_iir();
    wier(8'h04);
    chk_iir();
    for (int i = 0; i < 4; i++) clr(i);
    // Mid-run reset must bring the divisor byte and enables back to zero
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    pm = 4'h0;
    ier = 4'h0;
    fz = -1;
    #1 `CHK(div_high, 8'h00)
    chk_iir();
    u_host.rd(ADDR_IER_DLM, d);
    `CHK(d, 8'h00)
    setd(1'b1);
    u_host.wr(ADDR_IER_DLM, 8'h00);
    // Rates kept at or below the top supported speed
    for (int dv = 6; dv <= 12; dv += 6) begin
      @(posedge ref_clk) begin
        div_low <= 8'(dv);
        div_low_wr <= 1'b1;
      end
      @(posedge ref_clk) div_low_wr <= 1'b0;
      ticks = 0;
      repeat (dv * 3125 / 3) begin
        @(negedge ref_clk);
        ticks += int'(baud16_tick);
      end
      `CHK(ticks inside {[95:97]}, 1'b1)
    end
    end_of_test();
  end
endmodule : uart_baud_and_interrupt_id_tb
`default_nettype wire

// ===== tb/ubi_host.sv
`timescale 1ns/100ps
`default_nettype none
module ubi_host
  import ubi_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output var ubi_bus_t bus,
  input wire logic [7:0] rdata
);
  initial bus = '0;
  // Idle cycles carry changing junk so a stale address never looks like a request
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk) bus <= '{1'b1, 1'b0, 1'b1, a, v};
    @(posedge ref_clk) bus <= '{1'b0, 1'b0, 1'b0, ~a, ~v};
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk) bus <= '{1'b1, 1'b1, 1'b0, a, 8'h00};
    @(posedge ref_clk) bus <= '{1'b0, 1'b0, 1'b0, ~a, 8'($urandom)};
    #1 v = rdata;
  endtask : rd
endmodule : ubi_host
`default_nettype wire
